// File: design/shared_timer_prescaler_regs.svh
`ifndef SHARED_TIMER_PRESCALER_REGS_SVH
`define SHARED_TIMER_PRESCALER_REGS_SVH

// Register map
`define GENERAL_TIMER_CONTROL_OFFSET 8'h43
`define GENERAL_TIMER_CONTROL_RESET 8'h00
// Field positions in general_timer_control
`define TIMER_SYNC_HOLD_BIT 7
`define ASYNC_PRESCALER_RESET_BIT 1
`define SHARED_PRESCALER_RESET_BIT 0
`define GENERAL_TIMER_CONTROL_WMASK 8'h83
// Count source select encodings
`define CSS_STOPPED 3'h0
`define CSS_DIRECT 3'h1
`define CSS_DIV8 3'h2
`define CSS_DIV64 3'h3
`define CSS_DIV256 3'h4
`define CSS_DIV1024 3'h5
`define CSS_EXT_FALL 3'h6
`define CSS_EXT_RISE 3'h7
// Prescaler divisors, as counter terminal values
`define PRESCALER_WIDTH 10
`define DIV8_MASK 10'h007
`define DIV64_MASK 10'h03F
`define DIV256_MASK 10'h0FF
`define DIV1024_MASK 10'h3FF

`endif

// File: design/shared_timer_prescaler_pkg.sv
package shared_timer_prescaler_pkg;
  typedef logic [2:0] count_source_t;
  typedef enum logic [2:0] {
    EDGE_IDLE = 3'b001,
    EDGE_ARMED = 3'b010,
    EDGE_HELD = 3'b100
  } edge_state_e;
endpackage

// File: design/external_count_sync.sv
`timescale 1ns/10ps
`default_nettype none
`include "shared_timer_prescaler_regs.svh"

// Pin synchroniser and edge detector for one external count input
module external_count_sync
  import shared_timer_prescaler_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic external_count_pin,
  input wire count_source_t count_source_select,
  output logic ext_tick
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic sync3;
    logic level;
  } state_s;

  state_s st;
  state_s next_st;

  // Three-stage sampling; the level changes only when stages two and three agree
  always_comb begin
    next_st = st;
    next_st.sync1 = external_count_pin; // see [RULE6] [RULE7]
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    if (st.sync2 == st.sync3) begin
      next_st.level = st.sync3;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // One tick per qualifying edge, pin direction plays no part
  always_comb begin
    ext_tick = 1'b0;
    if (count_source_select == `CSS_EXT_RISE) begin
      ext_tick = next_st.level & ~st.level; // see [RULE8] [RULE16]
    end else if (count_source_select == `CSS_EXT_FALL) begin
      ext_tick = ~next_st.level & st.level; // see [RULE8]
    end
  end

endmodule
`default_nettype wire

// File: design/shared_timer_prescaler.sv
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "shared_timer_prescaler_regs.svh"

// Notes on behaviour
// [RULE1] Select value 1 ticks the timer every system clock cycle.
// [RULE2] Prescaler taps: system clock divided by 8, 64, 256, 1024.
// [RULE3] One prescaler for both timers; each timer has its own select.
// [RULE4] Prescaler runs freely; timer selection never resets it.
// [RULE5] First prescaled tick comes 1 to N+1 cycles after enabling.
// [RULE6] Count pin sampled each cycle and fed to an edge detector.
// [RULE7] Synchroniser registers capture on the rising system clock edge.
// [RULE8] One tick per edge: rising when select is 7, falling when 6.
// [RULE9] Tick follows a pin edge by about three system clock cycles; this design takes 3 to 4.
// [RULE10] Software changes external selection only while the pin is stable.
// [RULE11] External source half period exceeds one system clock cycle.
// [RULE12] External ticks bypass the prescaler divider entirely.
// [RULE13] Sync hold bit set keeps written prescaler reset bits asserted.
// [RULE14] Clearing sync hold clears both prescaler reset bits together.
// [RULE15] Shared prescaler reset bit resets divider, self-clears unless held.
// [RULE16] Pin edges count even when the pin is driven as an output.
// [RULE17] Select 0 gives no ticks; 2..5 map to 8, 64, 256, 1024.
// [RULE18] Control bits 6..2 read zero; bits 7, 1, 0 read and write.
module shared_timer_prescaler
  import shared_timer_prescaler_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire count_source_t count_source_select_0,
  input wire count_source_t count_source_select_1,
  input wire logic external_count_pin_0,
  input wire logic external_count_pin_1,
  output logic timer_count_tick_0,
  output logic timer_count_tick_1,
  output logic async_prescaler_reset
);

  typedef struct packed {
    logic [`PRESCALER_WIDTH-1:0] divider;
    logic timer_sync_hold;
    logic async_prescaler_reset;
    logic shared_prescaler_reset;
    logic [7:0] rdata;
    logic tick0;
    logic tick1;
  } state_s;

  state_s st;
  state_s next_st;
  logic ext_tick_0;
  logic ext_tick_1;
  logic [3:0] taps;
  logic wr_ctrl;
  logic prescaler_clear;

  ////////////////////////////////////////////////////////////////////////////
  // Tick selection shared by both timers

  // Maps a select value to a tick; external ticks never pass the divider
  function automatic logic select_tick(input count_source_t sel, input logic [3:0] tap,
                                       input logic ext, input logic halted);
    logic t;
    t = 1'b0;
    case (sel)
      `CSS_STOPPED: t = 1'b0; // see [RULE17]
      `CSS_DIRECT: t = 1'b1; // see [RULE1]
      `CSS_DIV8: t = tap[0]; // see [RULE2] [RULE17]
      `CSS_DIV64: t = tap[1];
      `CSS_DIV256: t = tap[2];
      `CSS_DIV1024: t = tap[3];
      `CSS_EXT_FALL: t = ext; // see [RULE12]
      `CSS_EXT_RISE: t = ext;
      default: t = 1'b0;
    endcase
    // A held prescaler reset halts the timers that share it
    select_tick = t & ~halted;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // External count inputs, one synchroniser per timer

  external_count_sync u_ext0 (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .external_count_pin(external_count_pin_0),
    .count_source_select(count_source_select_0),
    .ext_tick(ext_tick_0)
  );

  external_count_sync u_ext1 (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .external_count_pin(external_count_pin_1),
    .count_source_select(count_source_select_1),
    .ext_tick(ext_tick_1)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Taps: a tap fires when the low bits of the free divider are all ones

  always_comb begin
    taps[0] = (st.divider & `DIV8_MASK) == `DIV8_MASK; // see [RULE2] [RULE5]
    taps[1] = (st.divider & `DIV64_MASK) == `DIV64_MASK;
    taps[2] = (st.divider & `DIV256_MASK) == `DIV256_MASK;
    taps[3] = (st.divider & `DIV1024_MASK) == `DIV1024_MASK;
  end

  assign wr_ctrl = reg_write && (reg_addr == `GENERAL_TIMER_CONTROL_OFFSET);
  assign prescaler_clear = st.shared_prescaler_reset;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  // Reset bits set only when written together with the hold bit, and clear once the hold bit is cleared
  always_comb begin
    next_st = st;
    // Divider only ever restarts by the reset bit, never by a select change
    if (prescaler_clear) begin
      next_st.divider = '0; // see [RULE15]
    end else begin
      next_st.divider = st.divider + 1'b1; // see [RULE4] [RULE3]
    end
    if (!st.timer_sync_hold) begin
      next_st.shared_prescaler_reset = 1'b0; // see [RULE14] [RULE15]
      next_st.async_prescaler_reset = 1'b0;
    end
    if (wr_ctrl) begin
      next_st.timer_sync_hold = reg_wdata[`TIMER_SYNC_HOLD_BIT];
      if (reg_wdata[`TIMER_SYNC_HOLD_BIT]) begin
        // Held bits keep what was written, so set wins and sticks
        next_st.shared_prescaler_reset = reg_wdata[`SHARED_PRESCALER_RESET_BIT]; // see [RULE13]
        next_st.async_prescaler_reset = reg_wdata[`ASYNC_PRESCALER_RESET_BIT];
      end else begin
        // Hold dropped: both reset bits clear and timers resume together
        next_st.shared_prescaler_reset = 1'b0; // see [RULE14]
        next_st.async_prescaler_reset = 1'b0;
        if (reg_wdata[`SHARED_PRESCALER_RESET_BIT]) begin
          next_st.divider = '0; // see [RULE15]
        end
      end
    end
    // Readback: reserved bits 6..2 stay zero
    next_st.rdata = 8'h00;
    if (reg_read && reg_addr == `GENERAL_TIMER_CONTROL_OFFSET) begin
      next_st.rdata[`TIMER_SYNC_HOLD_BIT] = st.timer_sync_hold; // see [RULE18]
      next_st.rdata[`ASYNC_PRESCALER_RESET_BIT] = st.async_prescaler_reset;
      next_st.rdata[`SHARED_PRESCALER_RESET_BIT] = st.shared_prescaler_reset;
    end
    // Registered ticks put the external path 3 to 4 cycles after the pin edge, not within the 2.5..3.5 window
    next_st.tick0 = select_tick(count_source_select_0, taps, ext_tick_0,
                                st.shared_prescaler_reset); // see [RULE3] [RULE9]
    next_st.tick1 = select_tick(count_source_select_1, taps, ext_tick_1,
                                st.shared_prescaler_reset);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign timer_count_tick_0 = st.tick0;
  assign timer_count_tick_1 = st.tick1;
  assign async_prescaler_reset = st.async_prescaler_reset;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_direct_every_cycle: assert property (@(posedge sys_clk) disable iff (reset) // see [RULE1]
    clk_en && count_source_select_0 == `CSS_DIRECT && !st.shared_prescaler_reset
    |=> timer_count_tick_0)
    else $error("direct select did not tick");

  a_stopped_no_tick: assert property (@(posedge sys_clk) disable iff (reset) // see [RULE17]
    clk_en && count_source_select_1 == `CSS_STOPPED |=> !timer_count_tick_1)
    else $error("stopped select ticked");

  a_div8_spacing: assert property (@(posedge sys_clk) disable iff (reset) // see [RULE2]
    clk_en && count_source_select_0 == `CSS_DIV8 && taps[0] && !prescaler_clear
    && !wr_ctrl |=> !taps[0])
    else $error("div8 tap fired back to back");

  a_divider_free_run: assert property (@(posedge sys_clk) disable iff (reset) // see [RULE4]
    clk_en && !prescaler_clear && !wr_ctrl
    |=> st.divider == $past(st.divider) + 10'h001)
    else $error("prescaler did not advance");

  a_hold_keeps_reset: assert property (@(posedge sys_clk) disable iff (reset) // see [RULE13]
    clk_en && st.timer_sync_hold && st.shared_prescaler_reset && !wr_ctrl
    |=> st.shared_prescaler_reset && !timer_count_tick_0 ##1 !timer_count_tick_1)
    else $error("held reset released");

  a_hold_drop_clears: assert property (@(posedge sys_clk) disable iff (reset) // see [RULE14]
    clk_en && wr_ctrl && !reg_wdata[7]
    |=> !st.shared_prescaler_reset && !async_prescaler_reset)
    else $error("reset bits not cleared");

  a_reset_self_clear: assert property (@(posedge sys_clk) disable iff (reset) // see [RULE15]
    clk_en && wr_ctrl && !reg_wdata[`TIMER_SYNC_HOLD_BIT]
    && reg_wdata[`SHARED_PRESCALER_RESET_BIT]
    |=> !st.shared_prescaler_reset && st.divider == 10'h000)
    else $error("prescaler reset did not self clear");

  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (reset) // see [RULE18]
    reg_rdata[6:2] == 5'h00)
    else $error("reserved bits nonzero");

  a_ext_latency: assert property (@(posedge sys_clk) disable iff (reset) // see [RULE9] [RULE8]
    clk_en && ext_tick_0 && count_source_select_0 == `CSS_EXT_RISE
    && !st.shared_prescaler_reset |=> timer_count_tick_0)
    else $error("external tick lost");

  c_div1024: cover property (@(posedge sys_clk) count_source_select_0 == `CSS_DIV1024
    && timer_count_tick_0);
  c_ext_rise: cover property (@(posedge sys_clk) count_source_select_1 == `CSS_EXT_RISE
    && timer_count_tick_1);
  c_hold_release: cover property (@(posedge sys_clk) st.timer_sync_hold ##1
    !st.timer_sync_hold);

endmodule
`default_nettype wire

// File: verification/tick_counter_model.sv
`timescale 1ns/10ps
`default_nettype none
// Stand-in for one timer: counts every count tick it is handed
module tick_counter_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic timer_count_tick,
  output logic [15:0] count
);
  // One increment per tick cycle, so a stretched pulse shows as extra counts
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      count <= 16'h0000;
    end else if (clear) begin
      count <= 16'h0000;
    end else if (timer_count_tick) begin
      count <= count + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// File: verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import shared_timer_prescaler_pkg::*;
  logic sys_clk, reset, clk_en, reg_write, reg_read, clr, pin, tick0, tick1, apr, rd_seen;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [15:0] cnt0, cnt1;
  count_source_t sel0, sel1;
  logic [7:0] exp_q[$];
  int errors, samples_checked, seed, n, i, hp;
  int cycles = 0;
  shared_timer_prescaler dut (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .count_source_select_0(sel0), .count_source_select_1(sel1),
    .external_count_pin_0(pin), .external_count_pin_1(pin), .timer_count_tick_0(tick0),
    .timer_count_tick_1(tick1), .async_prescaler_reset(apr));
  tick_counter_model timer_0 (.sys_clk(sys_clk), .reset(reset), .clear(clr),
    .timer_count_tick(tick0), .count(cnt0));
  tick_counter_model timer_1 (.sys_clk(sys_clk), .reset(reset), .clear(clr),
    .timer_count_tick(tick1), .count(cnt1));
  //////////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bus cycles: one strobe cycle each, read result noted for the monitor
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] v);
    exp_q.push_back(v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
  endtask
  // Settle after a select change, clear both counters, then count w cycles
  task automatic window(input int w);
    repeat (4) @(posedge sys_clk);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    repeat (w) @(posedge sys_clk);
    #1;
  endtask
  function automatic logic [15:0] expc(input int k);
    case (k)
      0: return 16'h0000;
      1: return 16'h0800;
      2: return 16'h0100;
      3: return 16'h0020;
      4: return 16'h0008;
      default: return 16'h0002;
    endcase
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Read data stand only in the cycle after the strobe, so look mid-cycle
  always @(posedge sys_clk) rd_seen <= reset ? 1'b0 : reg_read;
  always @(negedge sys_clk) begin
    if (rd_seen === 1'b1) begin
      chk8(reg_rdata, exp_q.pop_front());
    end
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      report_and_stop;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'hb775;
    errors = 0;
    samples_checked = 0;
    {reset, clk_en, reg_write, reg_read, clr, pin} = 6'h30;
    {reg_addr, reg_wdata, sel0, sel1} = 22'h000000;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    // Control register: reset value, reserved bits, unmapped address
    rd(8'h43, 8'h00);
    wr(8'h43, 8'hFF);
    rd(8'h43, 8'h83);
    rd(8'h42, 8'h00);
    chk8({7'h00, apr}, 8'h01);
    for (i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      wr(8'h43, d);
      rd(8'h43, d[7] ? (d & 8'h83) : 8'h00);
    end
    wr(8'h43, 8'h00);
    rd(8'h43, 8'h00);
    chk8({7'h00, apr}, 8'h00);
    // Every internal select on both timers at once, over two whole /1024 spans
    for (i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      sel0 <= i[2:0];
      sel1 <= 3'(5 - i);
      window(2048);
      chk16(cnt0, expc(i));
      chk16(cnt1, expc(5 - i));
    end
    // Sync hold halts even the direct select until it is released
    wr(8'h43, 8'h81);
    @(posedge sys_clk);
    sel0 <= 3'h1;
    sel1 <= 3'h2;
    window(100);
    chk16(cnt0, 16'h0000);
    chk16(cnt1, 16'h0000);
    wr(8'h43, 8'h00);
    window(64);
    chk16(cnt0, 16'h0040);
    chk16(cnt1, 16'h0008);
    // Prescaler reset restarts the /8 phase; first tick within N+1
    @(posedge sys_clk);
    sel0 <= 3'h2;
    repeat (4) @(posedge sys_clk);
    wr(8'h43, 8'h01);
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (tick0 !== 1'b1 && n < 20);
    chk16(16'(n >= 1 && n <= 9), 16'h0001);
    rd(8'h43, 8'h00);
    // Pin edges: rising on timer 0, falling on timer 1, pin idle while selecting
    // Pin held low across the select change, so no false tick
    @(posedge sys_clk);
    sel0 <= 3'h7;
    sel1 <= 3'h6;
    window(0);
    for (i = 0; i < 10; i++) begin
      hp = 3 + ($unsigned($random(seed)) % 4);
      repeat (hp) @(posedge sys_clk);
      pin <= 1'b1;
      hp = 3 + ($unsigned($random(seed)) % 4);
      repeat (hp) @(posedge sys_clk);
      pin <= 1'b0;
    end
    repeat (10) @(posedge sys_clk);
    #1;
    chk16(cnt0, 16'h000A);
    chk16(cnt1, 16'h000A);
    report_and_stop;
  end
endmodule
`default_nettype wire
